// [servo_axis_ctrl.sv]
// servo axis: dual feedback blend, emergency stop deceleration and gate-off sequencing
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module servo_axis_ctrl #(
	parameter int unsigned TICK_CYCLES = servo_axis_pkg::TICK_CYCLES
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_estop_in,
	input  wire logic        i_nc_power_down,
	input  wire logic        i_drive_alarm,
	input  wire logic        i_db_alarm,
	input  wire logic        i_partner_db,
	input  wire logic [31:0] i_motor_pos,
	input  wire logic [31:0] i_machine_pos,
	input  wire logic [31:0] i_speed_ref,
	output logic [31:0]      o_speed_cmd,
	output logic [31:0]      o_position_fb,
	output logic             o_ready,
	output logic             o_gate_on,
	output logic             o_dyn_brake,
	output logic             o_brake_hold,
	output logic             o_partner_db,
	output logic             o_irq
);
	localparam int unsigned NE = servo_axis_pkg::NUM_EVENTS;
	localparam int unsigned NP = servo_axis_pkg::NUM_PINS;

	// pin synchronisers
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] pin_meta_r;
	logic [NP-1:0] pin_s_r;
	assign pin_raw = {i_partner_db, i_db_alarm, i_drive_alarm, i_nc_power_down, i_estop_in};

	genvar g;
	generate
		for (g = 0; g < NP; g++) begin : g_sync
			always_ff @(posedge i_sys_clk) begin
				// held as asserted, so no false READY before the pins are seen
				if (i_rst) begin
					pin_meta_r[g] <= 1'b1;
					pin_s_r[g]    <= 1'b1;
				end else begin
					pin_meta_r[g] <= pin_raw[g];
					pin_s_r[g]    <= pin_meta_r[g];
				end
			end
		end
	endgenerate

	logic estop_s;
	logic pwr_down_s;
	logic drv_alarm_s;
	logic db_alarm_s;
	logic partner_db_s;
	logic pwr_down_d_r;
	assign estop_s      = pin_s_r[servo_axis_pkg::PIN_ESTOP];
	assign pwr_down_s   = pin_s_r[servo_axis_pkg::PIN_PWR_DOWN];
	assign drv_alarm_s  = pin_s_r[servo_axis_pkg::PIN_DRV_ALARM];
	assign db_alarm_s   = pin_s_r[servo_axis_pkg::PIN_DB_ALARM];
	assign partner_db_s = pin_s_r[servo_axis_pkg::PIN_PARTNER_DB];

	// control tick divider
	logic [31:0] div_cnt_r;
	logic        tick_r;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			div_cnt_r <= 32'h0000_0000;
			tick_r    <= 1'b0;
		end else if (div_cnt_r == 32'(TICK_CYCLES - 1)) begin
			div_cnt_r <= 32'h0000_0000;
			tick_r    <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 32'h0000_0001;
			tick_r    <= 1'b0;
		end
	end

	// register bus: one wait state on every access
	logic        bus_req;
	logic        wr_en;
	assign bus_req = i_avs_read | i_avs_write;
	assign wr_en   = i_avs_write & ~o_avs_waitrequest;

	logic [31:0] spec_r;
	logic [15:0] dfb_tc_r;
	logic [15:0] dead_band_r;
	logic [15:0] decel_tc_r;
	logic [15:0] gate_delay_r;
	logic [15:0] drop_time_r;
	logic [31:0] rapid_rate_r;
	logic [NE-1:0] irq_en_r;
	logic [NE-1:0] irq_stat_r;
	logic [NE-1:0] irq_clr;
	logic        dfb_active_r;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			spec_r       <= servo_axis_pkg::SPEC_RST;
			dfb_tc_r     <= servo_axis_pkg::DFB_TC_RST;
			dead_band_r  <= servo_axis_pkg::DEAD_BAND_RST;
			decel_tc_r   <= servo_axis_pkg::DECEL_TC_RST;
			gate_delay_r <= servo_axis_pkg::GATE_DELAY_RST;
			drop_time_r  <= servo_axis_pkg::DROP_TIME_RST;
			rapid_rate_r <= servo_axis_pkg::RAPID_RATE_RST;
			irq_en_r     <= servo_axis_pkg::IRQ_ENABLE_RST;
		end else if (wr_en) begin
			if (i_avs_address == servo_axis_pkg::OFS_SPEC_WORD) begin
				spec_r <= i_avs_writedata;
			end else if (i_avs_address == servo_axis_pkg::OFS_DFB_TC) begin
				dfb_tc_r <= servo_axis_pkg::clamp16(i_avs_writedata[15:0],
					servo_axis_pkg::DFB_TC_MAX);
			end else if (i_avs_address == servo_axis_pkg::OFS_DEAD_BAND) begin
				dead_band_r <= servo_axis_pkg::clamp16(i_avs_writedata[15:0],
					servo_axis_pkg::DEAD_BAND_MAX);
			end else if (i_avs_address == servo_axis_pkg::OFS_DECEL_TC) begin
				// signed: negative marks a synchronous pair, magnitude is the time
				decel_tc_r <= i_avs_writedata[15:0];
			end else if (i_avs_address == servo_axis_pkg::OFS_GATE_DELAY) begin
				gate_delay_r <= servo_axis_pkg::clamp16(i_avs_writedata[15:0],
					servo_axis_pkg::MS_SETTING_MAX);
			end else if (i_avs_address == servo_axis_pkg::OFS_DROP_TIME) begin
				drop_time_r <= servo_axis_pkg::clamp16(i_avs_writedata[15:0],
					servo_axis_pkg::MS_SETTING_MAX);
			end else if (i_avs_address == servo_axis_pkg::OFS_RAPID_RATE) begin
				rapid_rate_r <= i_avs_writedata;
			end else if (i_avs_address == servo_axis_pkg::OFS_IRQ_ENABLE) begin
				irq_en_r <= i_avs_writedata[NE-1:0];
			end
		end
	end

	assign irq_clr = (wr_en && i_avs_address == servo_axis_pkg::OFS_IRQ_CLEAR)
		? i_avs_writedata[NE-1:0] : '0;

	// enable bit is only taken up when controller power returns
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pwr_down_d_r <= 1'b0;
			dfb_active_r <= 1'b0;
		end else begin
			pwr_down_d_r <= pwr_down_s;
			if (pwr_down_d_r && !pwr_down_s) begin
				dfb_active_r <= spec_r[servo_axis_pkg::SPEC_DFB_BIT];
			end
		end
	end

	// emergency stop settings
	logic        sync_pair;
	logic [15:0] decel_mag;
	logic [15:0] decel_eff;
	logic [15:0] gate_limit;
	logic        drop_en;
	logic        decel_en;
	assign sync_pair = decel_tc_r[15];
	assign decel_mag = sync_pair ? 16'(-decel_tc_r) : decel_tc_r;
	assign decel_eff = servo_axis_pkg::clamp16(decel_mag, servo_axis_pkg::MS_SETTING_MAX);
	assign drop_en   = spec_r[servo_axis_pkg::SPEC_DROP_BIT];
	assign decel_en  = spec_r[servo_axis_pkg::SPEC_DECEL_BIT];
	// drop prevention never lets gate off come early
	assign gate_limit = (drop_en && drop_time_r > gate_delay_r) ? drop_time_r
		: gate_delay_r;

	logic estop_any;
	logic db_request;
	assign estop_any  = estop_s | pwr_down_s | drv_alarm_s | db_alarm_s;
	assign db_request = db_alarm_s | (sync_pair & partner_db_s);

	// sequencer
	servo_axis_pkg::axis_state_t state_r;
	servo_axis_pkg::axis_state_t state_nxt;
	logic [15:0]        ms_cnt_r;
	logic signed [31:0] speed_r;
	logic signed [31:0] speed_nxt;
	logic signed [31:0] step;
	logic               standstill;
	logic               gate_expired;

	// one slope from rapid rate, so slower starts stop sooner
	assign step = (decel_eff == 16'h0000) ? 32'sh7FFF_FFFF
		: $signed(rapid_rate_r / {16'h0000, decel_eff});
	assign standstill   = (speed_r == 32'sh0000_0000);
	assign gate_expired = (ms_cnt_r >= gate_limit);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			servo_axis_pkg::ST_RUN: begin
				if (db_request) begin
					state_nxt = servo_axis_pkg::ST_BRAKE;
				end else if (estop_any) begin
					if (!decel_en) begin
						state_nxt = servo_axis_pkg::ST_BRAKE;
					end else begin
						state_nxt = servo_axis_pkg::ST_DECEL;
					end
				end
			end
			servo_axis_pkg::ST_DECEL: begin
				if (db_request || gate_expired) begin
					state_nxt = servo_axis_pkg::ST_BRAKE;
				end else if (standstill) begin
					state_nxt = drop_en ? servo_axis_pkg::ST_HOLD
						: servo_axis_pkg::ST_BRAKE;
				end
			end
			servo_axis_pkg::ST_HOLD: begin
				// stay powered until the brake has taken the load
				if (db_request || gate_expired || ms_cnt_r >= drop_time_r) begin
					state_nxt = servo_axis_pkg::ST_BRAKE;
				end
			end
			servo_axis_pkg::ST_BRAKE: begin
				if (!estop_any && !partner_db_s) begin
					state_nxt = servo_axis_pkg::ST_RUN;
				end
			end
			default: begin
				state_nxt = servo_axis_pkg::ST_BRAKE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_r <= servo_axis_pkg::ST_BRAKE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// time since the emergency stop, in ticks
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			ms_cnt_r <= 16'h0000;
		end else if (state_r == servo_axis_pkg::ST_RUN) begin
			ms_cnt_r <= 16'h0000;
		end else if (tick_r && ms_cnt_r != 16'hFFFF) begin
			ms_cnt_r <= ms_cnt_r + 16'h0001;
		end
	end

	always_comb begin
		speed_nxt = speed_r;
		case (state_nxt)
			servo_axis_pkg::ST_RUN: begin
				speed_nxt = $signed(i_speed_ref);
			end
			servo_axis_pkg::ST_DECEL: begin
				if (tick_r || decel_eff == 16'h0000) begin
					// zero constant gives a position-loop step stop
					if (speed_r > step) begin
						speed_nxt = speed_r - step;
					end else if (speed_r < -step) begin
						speed_nxt = speed_r + step;
					end else begin
						speed_nxt = 32'sh0000_0000;
					end
				end
			end
			default: begin
				speed_nxt = 32'sh0000_0000;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			speed_r <= 32'sh0000_0000;
		end else begin
			speed_r <= speed_nxt;
		end
	end

	// output stage, all from flip-flops
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_ready      <= 1'b0;
			o_gate_on    <= 1'b0;
			o_dyn_brake  <= 1'b1;
			o_brake_hold <= 1'b1;
			o_partner_db <= 1'b0;
			o_speed_cmd  <= 32'h0000_0000;
		end else begin
			o_ready      <= (state_nxt != servo_axis_pkg::ST_BRAKE);
			o_gate_on    <= (state_nxt != servo_axis_pkg::ST_BRAKE);
			o_dyn_brake  <= (state_nxt == servo_axis_pkg::ST_BRAKE);
			o_brake_hold <= (state_nxt != servo_axis_pkg::ST_RUN);
			o_partner_db <= sync_pair & db_alarm_s;
			o_speed_cmd  <= speed_nxt;
		end
	end

	// sticky events; a new event beats a clear in the same cycle
	logic [NE-1:0] ev;
	assign ev[servo_axis_pkg::EV_ESTOP]      = (state_r == servo_axis_pkg::ST_RUN) && estop_any;
	assign ev[servo_axis_pkg::EV_STANDSTILL] = (state_r == servo_axis_pkg::ST_DECEL)
		&& (state_nxt == servo_axis_pkg::ST_HOLD
		|| (state_nxt == servo_axis_pkg::ST_BRAKE && standstill && !db_request));
	assign ev[servo_axis_pkg::EV_GATE_OFF]   = (state_r != servo_axis_pkg::ST_BRAKE)
		&& (state_r != servo_axis_pkg::ST_RUN) && gate_expired;
	assign ev[servo_axis_pkg::EV_DYN_BRAKE]  = (state_r != servo_axis_pkg::ST_BRAKE)
		&& (state_nxt == servo_axis_pkg::ST_BRAKE);

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			irq_stat_r <= '0;
			o_irq      <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | ev;
			o_irq      <= |(((irq_stat_r & ~irq_clr) | ev) & irq_en_r);
		end
	end

	// read data, registered on the edge that ends the wait state
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (i_avs_address == servo_axis_pkg::OFS_SPEC_WORD) begin
			rd_mux = spec_r;
		end else if (i_avs_address == servo_axis_pkg::OFS_DFB_TC) begin
			rd_mux = {16'h0000, dfb_tc_r};
		end else if (i_avs_address == servo_axis_pkg::OFS_DEAD_BAND) begin
			rd_mux = {16'h0000, dead_band_r};
		end else if (i_avs_address == servo_axis_pkg::OFS_DECEL_TC) begin
			rd_mux = {16'h0000, decel_tc_r};
		end else if (i_avs_address == servo_axis_pkg::OFS_GATE_DELAY) begin
			rd_mux = {16'h0000, gate_delay_r};
		end else if (i_avs_address == servo_axis_pkg::OFS_DROP_TIME) begin
			rd_mux = {16'h0000, drop_time_r};
		end else if (i_avs_address == servo_axis_pkg::OFS_RAPID_RATE) begin
			rd_mux = rapid_rate_r;
		end else if (i_avs_address == servo_axis_pkg::OFS_STATUS) begin
			rd_mux = {ms_cnt_r, 8'h00, estop_any, dfb_active_r, o_dyn_brake,
				o_gate_on, o_ready, standstill, state_r};
		end else if (i_avs_address == servo_axis_pkg::OFS_IRQ_STATUS) begin
			rd_mux = {28'h0000000, irq_stat_r};
		end else if (i_avs_address == servo_axis_pkg::OFS_IRQ_ENABLE) begin
			rd_mux = {28'h0000000, irq_en_r};
		end else if (i_avs_address == servo_axis_pkg::OFS_SPEED_CMD) begin
			rd_mux = o_speed_cmd;
		end else if (i_avs_address == servo_axis_pkg::OFS_POS_FB) begin
			rd_mux = o_position_fb;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read && o_avs_waitrequest) begin
			o_avs_readdata <= rd_mux;
		end
	end

	// feedback blend
	servo_axis_pkg::dfb_cfg_t dfb_cfg;
	servo_axis_pkg::fb_pair_t fb_in;
	logic signed [31:0]       fb_out;
	assign dfb_cfg       = '{enable: dfb_active_r, time_constant: dfb_tc_r, dead_band: dead_band_r};
	assign fb_in         = '{motor: $signed(i_motor_pos), machine: $signed(i_machine_pos)};
	assign o_position_fb = fb_out;

	dual_fb_filter u_dfb (
		.i_sys_clk     (i_sys_clk),
		.i_rst         (i_rst),
		.i_tick        (tick_r),
		.i_cfg         (dfb_cfg),
		.i_fb          (fb_in),
		.o_position_fb (fb_out)
	);
endmodule

// [servo_axis_pkg.sv]
// shared constants, types and register map of the servo axis block
package servo_axis_pkg;
	// control tick
	localparam int unsigned CLK_FREQ_HZ     = 25000000;
	localparam int unsigned TICK_PERIOD_MS  = 1;
	localparam int unsigned TICK_CYCLES     = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
	// setting ranges
	localparam logic [15:0] DFB_TC_MAX      = 16'h270F;
	localparam logic [15:0] DFB_TC_ZERO_AS  = 16'h0001;
	localparam logic [15:0] DEAD_BAND_MAX   = 16'h270F;
	localparam logic [15:0] MS_SETTING_MAX  = 16'h4E20;
	// register byte addresses
	localparam logic [7:0]  OFS_SPEC_WORD   = 8'h00;
	localparam logic [7:0]  OFS_DFB_TC      = 8'h04;
	localparam logic [7:0]  OFS_DEAD_BAND   = 8'h08;
	localparam logic [7:0]  OFS_DECEL_TC    = 8'h0C;
	localparam logic [7:0]  OFS_GATE_DELAY  = 8'h10;
	localparam logic [7:0]  OFS_DROP_TIME   = 8'h14;
	localparam logic [7:0]  OFS_RAPID_RATE  = 8'h18;
	localparam logic [7:0]  OFS_STATUS      = 8'h1C;
	localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h20;
	localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h24;
	localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h28;
	localparam logic [7:0]  OFS_SPEED_CMD   = 8'h2C;
	localparam logic [7:0]  OFS_POS_FB      = 8'h30;
	// servo_spec_word_1 / control field positions
	localparam int unsigned SPEC_DFB_BIT    = 1;
	localparam int unsigned SPEC_DECEL_BIT  = 2;
	localparam int unsigned SPEC_DROP_BIT   = 3;
	// reset values
	localparam logic [31:0] SPEC_RST        = 32'h0000_0000;
	localparam logic [15:0] DFB_TC_RST      = 16'h0000;
	localparam logic [15:0] DEAD_BAND_RST   = 16'h0000;
	localparam logic [15:0] DECEL_TC_RST    = 16'h0000;
	localparam logic [15:0] GATE_DELAY_RST  = 16'h0000;
	localparam logic [15:0] DROP_TIME_RST   = 16'h0000;
	localparam logic [31:0] RAPID_RATE_RST  = 32'h0000_0000;
	localparam logic [3:0]  IRQ_ENABLE_RST  = 4'h0;
	// interrupt event bits
	localparam int unsigned EV_ESTOP        = 0;
	localparam int unsigned EV_STANDSTILL   = 1;
	localparam int unsigned EV_GATE_OFF     = 2;
	localparam int unsigned EV_DYN_BRAKE    = 3;
	localparam int unsigned NUM_EVENTS      = 4;
	// synchronised pin inputs
	localparam int unsigned PIN_ESTOP       = 0;
	localparam int unsigned PIN_PWR_DOWN    = 1;
	localparam int unsigned PIN_DRV_ALARM   = 2;
	localparam int unsigned PIN_DB_ALARM    = 3;
	localparam int unsigned PIN_PARTNER_DB  = 4;
	localparam int unsigned NUM_PINS        = 5;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_DECEL = 2'b01,
		ST_HOLD  = 2'b10,
		ST_BRAKE = 2'b11
	} axis_state_t;

	typedef struct packed {
		logic signed [31:0] motor;
		logic signed [31:0] machine;
	} fb_pair_t;

	typedef struct packed {
		logic        enable;
		logic [15:0] time_constant;
		logic [15:0] dead_band;
	} dfb_cfg_t;

	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] max);
		clamp16 = (v > max) ? max : v;
	endfunction
endpackage

// [dual_fb_filter.sv]
// primary-delay blend of motor-side and machine-side position feedback
`timescale 1ns/1ns
module dual_fb_filter (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst,
	input  wire logic                      i_tick,
	input  wire servo_axis_pkg::dfb_cfg_t  i_cfg,
	input  wire servo_axis_pkg::fb_pair_t  i_fb,
	output logic signed [31:0]             o_position_fb
);
	logic signed [31:0] gap_r;
	logic signed [31:0] gap_nxt;
	logic signed [31:0] err;
	logic signed [31:0] diff;
	logic signed [31:0] mag;
	logic [15:0]        tc_eff;

	// zero is run as the shortest constant
	assign tc_eff = (i_cfg.time_constant == 16'h0000) ? servo_axis_pkg::DFB_TC_ZERO_AS
		: i_cfg.time_constant;
	assign err  = i_fb.machine - i_fb.motor;
	assign diff = err - gap_r;
	assign mag  = diff[31] ? -diff : diff;

	always_comb begin
		gap_nxt = gap_r;
		if (!i_cfg.enable) begin
			gap_nxt = 32'sh0000_0000;
		end else if (i_tick && (mag > $signed({16'h0000, i_cfg.dead_band}))) begin
			// larger constant keeps the motor side longer, nearer semi-closed
			gap_nxt = gap_r + diff / $signed({16'h0000, tc_eff});
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			gap_r <= 32'sh0000_0000;
		end else begin
			gap_r <= gap_nxt;
		end
	end

	// blended when enabled, plain machine side otherwise
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_position_fb <= 32'sh0000_0000;
		end else if (i_cfg.enable) begin
			o_position_fb <= i_fb.motor + gap_nxt;
		end else begin
			o_position_fb <= i_fb.machine;
		end
	end
endmodule

// [servo_axis_chk.sv]
// port-level assertions for the servo axis block
`timescale 1ns/1ns
module servo_axis_chk #(
	parameter int unsigned TICK_CYCLES = 10
) (
	input wire logic        i_sys_clk,
	input wire logic        i_rst,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic        o_avs_waitrequest,
	input wire logic        i_estop_in,
	input wire logic        i_db_alarm,
	input wire logic [31:0] o_speed_cmd,
	input wire logic        o_ready,
	input wire logic        o_gate_on,
	input wire logic        o_dyn_brake,
	input wire logic        o_brake_hold,
	input wire logic        o_partner_db
);
	logic [31:0] spd_mag;
	// speed is signed, so compare magnitudes
	assign spd_mag = o_speed_cmd[31] ? -o_speed_cmd : o_speed_cmd;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	bus_ack_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("request not answered next cycle");
	wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	gate_ready_a: assert property (o_gate_on == o_ready)
		else $error("gate and ready differ");
	brake_ready_a: assert property (o_dyn_brake |-> !o_ready)
		else $error("ready kept during dynamic braking");
	estop_hold_a: assert property (i_estop_in |-> ##[1:4] o_brake_hold)
		else $error("stop input not taken");
	db_brake_a: assert property (i_db_alarm |-> ##[1:4] o_dyn_brake)
		else $error("braking alarm did not brake");
	ramp_down_a: assert property (o_ready && o_brake_hold && $past(o_ready && o_brake_hold)
		|-> spd_mag <= $past(spd_mag))
		else $error("speed rose during deceleration");
	pair_db_a: assert property (o_partner_db |-> ##[0:3] o_dyn_brake)
		else $error("partner told of braking without own braking");
	decel_c: cover property (o_ready && o_brake_hold);
	brake_c: cover property ($rose(o_dyn_brake));
	pair_c: cover property (o_partner_db);
endmodule

bind servo_axis_ctrl servo_axis_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
	.i_sys_clk         (i_sys_clk),
	.i_rst             (i_rst),
	.i_avs_read        (i_avs_read),
	.i_avs_write       (i_avs_write),
	.o_avs_waitrequest (o_avs_waitrequest),
	.i_estop_in        (i_estop_in),
	.i_db_alarm        (i_db_alarm),
	.o_speed_cmd       (o_speed_cmd),
	.o_ready           (o_ready),
	.o_gate_on         (o_gate_on),
	.o_dyn_brake       (o_dyn_brake),
	.o_brake_hold      (o_brake_hold),
	.o_partner_db      (o_partner_db)
);

// [nc_model.sv]
// behavioural numerical controller: speed commands and stop events
`timescale 1ns/1ns
module nc_model (
	input  wire logic   i_sys_clk,
	output logic [31:0] o_speed_ref,
	output logic        o_estop,
	output logic        o_power_down
);
	initial begin
		o_speed_ref = 32'h0;
		o_estop = 1'b0;
		o_power_down = 1'b0;
	end
	task automatic set_speed(input logic [31:0] v);
		@(posedge i_sys_clk);
		o_speed_ref <= v;
	endtask
	task automatic stop(input logic on);
		@(posedge i_sys_clk);
		o_estop <= on;
	endtask
	// power loss is also a stop cause, so callers wait for ready afterwards
	task automatic power(input logic on);
		@(posedge i_sys_clk);
		o_power_down <= on;
	endtask
endmodule

// [servo_axis_ctrl_tb_top.sv]
// self-checking bench of the servo axis block
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module servo_axis_ctrl_tb_top;
	typedef struct packed {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} row_t;
	localparam row_t ROWS [7] = '{
		'{1'b0, servo_axis_pkg::OFS_SPEC_WORD, 32'h0, 32'h0},
		'{1'b1, servo_axis_pkg::OFS_DFB_TC, 32'hFFFF, 32'h270F},
		'{1'b1, servo_axis_pkg::OFS_DEAD_BAND, 32'h2710, 32'h270F},
		'{1'b1, servo_axis_pkg::OFS_GATE_DELAY, 32'h4E21, 32'h4E20},
		'{1'b1, servo_axis_pkg::OFS_DROP_TIME, 32'hFFFF, 32'h4E20},
		'{1'b1, servo_axis_pkg::OFS_DECEL_TC, 32'h4E21, 32'h4E21},
		'{1'b0, 8'h3C, 32'h0, 32'h0}};
	logic        clk, rst, rd, wr, drv_al, db_al, p_db, wq, rdy, gate, dyb, bh, pdb, irq, est, pwd;
	logic [7:0]  adr;
	logic [31:0] wd, rq, q, mot, mach, sref, spd, pfb, p0;
	int          err_count, comparisons, n;
	servo_axis_ctrl #(.TICK_CYCLES(10)) i_dut (
		.i_sys_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rq),
		.o_avs_waitrequest(wq), .i_estop_in(est), .i_nc_power_down(pwd),
		.i_drive_alarm(drv_al), .i_db_alarm(db_al), .i_partner_db(p_db),
		.i_motor_pos(mot), .i_machine_pos(mach), .i_speed_ref(sref), .o_speed_cmd(spd),
		.o_position_fb(pfb), .o_ready(rdy), .o_gate_on(gate), .o_dyn_brake(dyb),
		.o_brake_hold(bh), .o_partner_db(pdb), .o_irq(irq));
	nc_model i_nc (.i_sys_clk(clk), .o_speed_ref(sref), .o_estop(est), .o_power_down(pwd));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic wt(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic bus(input logic w_, input logic [7:0] a_, input logic [31:0] d_);
		@(posedge clk);
		adr <= a_;
		wd <= d_;
		rd <= !w_;
		wr <= w_;
		do begin
			@(posedge clk);
		end while (wq !== 1'b0);
		q = rq;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic run();
		drv_al <= 1'b0;
		db_al <= 1'b0;
		p_db <= 1'b0;
		i_nc.stop(1'b0);
		for (n = 0; n < 100 && rdy !== 1'b1; n++) @(posedge clk);
	endtask
	task automatic decel(input logic [31:0] v, input logic [31:0] e);
		i_nc.set_speed(v);
		wt(5);
		i_nc.stop(1'b1);
		for (n = 0; n < 40 && spd === v; n++) @(posedge clk);
		`CHK("first step", e, spd)
		`CHK("ready in decel", 1'b1, rdy)
		wt(10);
		`CHK("second step", e - 32'h64, spd)
		for (n = 0; n < 200 && dyb !== 1'b1; n++) @(posedge clk);
		`CHK("stopped at brake", 32'h0, spd)
	endtask
	task automatic final_report();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		final_report();
	end
	initial begin
		{rst, rd, wr, drv_al, db_al, p_db} = 6'h20;
		{adr, wd, mot, mach} = '0;
		err_count = 0;
		comparisons = 0;
		wt(16);
		rst <= 1'b0;
		run();
		`CHK("ready after reset", 1'b1, rdy)
		foreach (ROWS[i]) begin
			if (ROWS[i].wr) bus(1'b1, ROWS[i].a, ROWS[i].d);
			bus(1'b0, ROWS[i].a, 32'h0);
			`CHK("register", ROWS[i].e, q)
		end
		// decel disabled: every cause goes straight to braking
		bus(1'b1, servo_axis_pkg::OFS_SPEC_WORD, 32'h0);
		for (int k = 0; k < 3; k++) begin
			if (k == 0) i_nc.stop(1'b1);
			if (k == 1) i_nc.power(1'b1);
			if (k == 2) drv_al <= 1'b1;
			wt(6);
			`CHK("cause brakes", 1'b1, dyb)
			i_nc.power(1'b0);
			run();
		end
		// gate delay kept above the decel constant, and 0.9 margin kept
		bus(1'b1, servo_axis_pkg::OFS_RAPID_RATE, 32'h3E8);
		bus(1'b1, servo_axis_pkg::OFS_DECEL_TC, 32'hA);
		bus(1'b1, servo_axis_pkg::OFS_GATE_DELAY, 32'h3E8);
		bus(1'b1, servo_axis_pkg::OFS_SPEC_WORD, 32'h4);
		decel(32'h3E8, 32'h384);
		bus(1'b0, servo_axis_pkg::OFS_IRQ_STATUS, 32'h0);
		`CHK("irq status", 32'hB, q)
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, servo_axis_pkg::OFS_IRQ_ENABLE, 32'h2);
		wt(2);
		`CHK("irq raised", 1'b1, irq)
		bus(1'b1, servo_axis_pkg::OFS_IRQ_CLEAR, 32'hF);
		wt(2);
		`CHK("irq cleared", 1'b0, irq)
		run();
		decel(32'h1F4, 32'h190);
		run();
		bus(1'b1, servo_axis_pkg::OFS_DECEL_TC, 32'h4E20);
		bus(1'b1, servo_axis_pkg::OFS_GATE_DELAY, 32'h5);
		i_nc.stop(1'b1);
		wt(35);
		`CHK("ready before gate limit", 1'b1, rdy)
		wt(40);
		`CHK("gate forced off", 1'b0, rdy)
		run();
		bus(1'b1, servo_axis_pkg::OFS_DECEL_TC, 32'h0);
		bus(1'b1, servo_axis_pkg::OFS_GATE_DELAY, 32'h2);
		bus(1'b1, servo_axis_pkg::OFS_DROP_TIME, 32'h8);
		bus(1'b1, servo_axis_pkg::OFS_SPEC_WORD, 32'hC);
		i_nc.stop(1'b1);
		wt(10);
		`CHK("step stop", 32'h0, spd)
		`CHK("brake engaging", 1'b1, bh)
		wt(55);
		`CHK("drop time holds ready", 1'b1, rdy)
		wt(45);
		`CHK("ready off after drop", 1'b0, rdy)
		run();
		bus(1'b1, servo_axis_pkg::OFS_DECEL_TC, 32'hA);
		db_al <= 1'b1;
		wt(6);
		`CHK("alarm brakes", 1'b1, dyb)
		run();
		bus(1'b1, servo_axis_pkg::OFS_DECEL_TC, 32'hFFF6);
		p_db <= 1'b1;
		wt(6);
		`CHK("partner brakes us", 1'b1, dyb)
		run();
		db_al <= 1'b1;
		wt(6);
		`CHK("we tell partner", 1'b1, pdb)
		run();
		bus(1'b1, servo_axis_pkg::OFS_SPEC_WORD, 32'h2);
		mot <= 32'h12C;
		mach <= 32'h64;
		wt(3);
		`CHK("blend off", 32'h64, pfb)
		bus(1'b0, servo_axis_pkg::OFS_STATUS, 32'h0);
		`CHK("not yet active", 1'b0, q[6])
		bus(1'b1, servo_axis_pkg::OFS_DFB_TC, 32'h64);
		mot <= 32'h0;
		i_nc.power(1'b1);
		wt(5);
		i_nc.power(1'b0);
		run();
		bus(1'b0, servo_axis_pkg::OFS_STATUS, 32'h0);
		`CHK("blend active", 1'b1, q[6])
		p0 = pfb;
		mot <= 32'h12C;
		wt(5);
		`CHK("motor side leads", 1'b1, ($signed(pfb) - $signed(p0)) > 250)
		i_nc.stop(1'b1);
		wt(8);
		rst <= 1'b1;
		wt(3);
		`CHK("reset ready", 1'b0, rdy)
		`CHK("reset brake", 1'b1, dyb)
		rst <= 1'b0;
		wt(2);
		`CHK("stop held over reset", 1'b0, rdy)
		run();
		`CHK("ready after second reset", 1'b1, rdy)
		final_report();
	end
endmodule
